/* common/tcct_defs.svh */
// Register offsets, field positions, reset values and counts of the timer.
`ifndef TCCT_DEFS_SVH
`define TCCT_DEFS_SVH
// ==============================
// Register byte addresses.
`define TCCT_A_CTRL 6'h00
`define TCCT_A_COUNT 6'h04
`define TCCT_A_MOD 6'h08
`define TCCT_A_C0CTL 6'h0c
`define TCCT_A_C0VAL 6'h10
`define TCCT_A_C1CTL 6'h14
`define TCCT_A_C1VAL 6'h18
`define TCCT_A_IST 6'h1c
`define TCCT_A_IMSK 6'h20
// ==============================
// Control register fields.
`define TCCT_CTRL_STOP 5
`define TCCT_CTRL_CLR 4
`define TCCT_SEL_HI 2
// Channel control fields.
`define TCCT_CH_LINK 5
`define TCCT_CH_CMP 4
`define TCCT_CH_ELS_HI 3
`define TCCT_CH_ELS_LO 2
`define TCCT_CH_TOV 1
// Interrupt status bits; channel n uses bit n+1.
`define TCCT_IRQ_OVF 0
`define TCCT_IRQ_W 3
// ==============================
// Reset values, the external clock select code and counts.
`define TCCT_STOP_RST 1'b1
`define TCCT_MOD_RST 16'hffff
`define TCCT_SEL_EXT 3'h7
`define TCCT_NCH 2
`endif

/* common/tcct_pkg.sv */
// Types shared by the timer modules.
package tcct_pkg;
   // Bus answer states.
   typedef enum logic [0:0] {
      TCCT_BUS_IDLE = 1'b0,
      TCCT_BUS_ACK = 1'b1
   } tcct_bus_state_type;
   // Edge select in capture mode, pin action in compare mode.
   typedef enum logic [1:0] {
      TCCT_ELS_OFF = 2'b00,
      TCCT_ELS_RISE_TOG = 2'b01,
      TCCT_ELS_FALL_CLR = 2'b10,
      TCCT_ELS_BOTH_SET = 2'b11
   } tcct_edge_type;
   // Per-channel configuration.
   typedef struct packed {
      logic link;
      logic cmp;
      tcct_edge_type els;
      logic tov;
   } tcct_chcfg_type;
endpackage

/* common/tcct_chan_if.sv */
// Interface between the timer core and one channel.
`timescale 1ns/100ps
interface tcct_chan_if;
   import tcct_pkg::*;
   logic [15:0] count; // Live counter value.
   logic tick; // Counter advances this cycle.
   logic ovf; // Counter wraps this cycle.
   tcct_chcfg_type cfg; // Channel configuration.
   logic [15:0] cmp_val; // Compare value in force.
   logic drive_en; // Channel may own its pin.
   logic pin_sync; // Synchronised pin level.
   logic cap_ev; // Qualifying capture edge.
   logic cmp_ev; // Compare match.
   logic pin_out; // Registered pin level.
   logic pin_oe; // Registered pin enable.
   modport timer (output count, tick, ovf, cfg, cmp_val, drive_en, pin_sync,
      input cap_ev, cmp_ev, pin_out, pin_oe);
   modport chan (input count, tick, ovf, cfg, cmp_val, drive_en, pin_sync,
      output cap_ev, cmp_ev, pin_out, pin_oe);
endinterface

/* hw/tcct_channel.sv */
// One capture/compare channel: edge detection and pin action.
`timescale 1ns/100ps
module tcct_channel (
   // Clock, reset and enable.
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   // Link to the timer core.
   tcct_chan_if.chan ch
);
   import tcct_pkg::*;
   logic pin_d_r; // Pin level one cycle back.
   logic pin_r; // Driven pin level.
   logic oe_r; // Pin drive enable.
   logic pin_d_nxt;
   logic pin_nxt;
   logic oe_nxt;
   logic rise;
   logic fall;
   // ==============================
   // Edge detection and compare action.
   always_comb begin
      rise = ch.pin_sync && !pin_d_r;
      fall = !ch.pin_sync && pin_d_r;
      pin_d_nxt = ch.pin_sync;
      // Capture fires on the selected edges only.
      ch.cap_ev = !ch.cfg.cmp && ((ch.cfg.els[0] && rise) || (ch.cfg.els[1] && fall)); // RL5
      ch.cmp_ev = ch.cfg.cmp && ch.drive_en && ch.tick && (ch.count == ch.cmp_val);
      pin_nxt = pin_r;
      if (ch.cmp_ev) begin
         // Compare wins over the overflow toggle.
         case (ch.cfg.els) // RL6
            TCCT_ELS_RISE_TOG: pin_nxt = !pin_r;
            TCCT_ELS_FALL_CLR: pin_nxt = 1'b0;
            TCCT_ELS_BOTH_SET: pin_nxt = 1'b1;
            default: pin_nxt = pin_r;
         endcase
      end else if (ch.cfg.cmp && ch.drive_en && ch.cfg.tov && ch.ovf) begin
         pin_nxt = !pin_r; // RL10
      end
      // Only a compare channel owns its pin.
      oe_nxt = ch.cfg.cmp && ch.drive_en; // RL4
   end
   // Registers of the channel.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pin_d_r <= 1'b0;
         pin_r <= 1'b0;
         oe_r <= 1'b0;
      end else if (ce) begin
         pin_d_r <= pin_d_nxt;
         pin_r <= pin_nxt;
         oe_r <= oe_nxt;
      end
   end
   assign ch.pin_out = pin_r;
   assign ch.pin_oe = oe_r;
   // ==============================
   // Checks.
   fall_cap_a: assert property (@(posedge ref_clk) disable iff (rst) // RL5
      ce && $past(ce) && !ch.cfg.cmp && ch.cfg.els == TCCT_ELS_FALL_CLR && $fell(ch.pin_sync) |-> ch.cap_ev)
      else $error("falling edge not captured");
   off_cap_a: assert property (@(posedge ref_clk) disable iff (rst) // RL5
      ch.cfg.els == TCCT_ELS_OFF |-> !ch.cap_ev)
      else $error("capture with edges off");
   cmp_set_a: assert property (@(posedge ref_clk) disable iff (rst) // RL6
      ce && ch.cmp_ev && ch.cfg.els == TCCT_ELS_BOTH_SET |=> ch.pin_out)
      else $error("pin not set on match");
   cmp_tog_a: assert property (@(posedge ref_clk) disable iff (rst) // RL6
      ce && ch.cmp_ev && ch.cfg.els == TCCT_ELS_RISE_TOG |=> ch.pin_out != $past(ch.pin_out))
      else $error("pin not toggled on match");
   ovf_tog_a: assert property (@(posedge ref_clk) disable iff (rst) // RL10
      ce && ch.cfg.cmp && ch.drive_en && ch.cfg.tov && ch.ovf && !ch.cmp_ev |=> ch.pin_out != $past(ch.pin_out))
      else $error("pin not toggled on overflow");
   cap_oe_a: assert property (@(posedge ref_clk) disable iff (rst) // RL4
      ce && !ch.cfg.cmp |=> !ch.pin_oe)
      else $error("capture channel drives pin");
endmodule

/* hw/tcct_top.sv */
// Two-channel capture/compare timer with Avalon-MM registers.
`timescale 1ns/100ps
`include "tcct_defs.svh"
// Function
// RL1: 16-bit up-counter, free-running or modulo.
// RL2: Wrap value comes from the modulo register.
// RL3: Counter reads never disturb counting.
// RL4: Each channel is capture or compare independently.
// RL5: Capture on rising, falling or both edges.
// RL6: Compare match sets, clears or toggles pin.
// RL7: Unbuffered and buffered PWM output forms.
// RL8: Seven prescaled bus clock divisions.
// RL9: External clock pin, at most 4 MHz.
// RL10: Channel pin may toggle on overflow.
// RL11: Software can stop and reset counter.
// RL12: Three-bit select picks counter clock source.
// RL13: Captured value is preceding count plus two.
// RL14: Every qualifying edge captures, flag or not.
// RL15: At modulo, flag overflow and restart zero.
module tcct_top (
   // Clock, reset and clock enable.
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   // Avalon-MM slave.
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // External counter clock pin.
   input wire logic ext_clk_pin,
   // Channel pins.
   input wire logic [1:0] ch_pin_in,
   output logic [1:0] ch_pin_out,
   output logic [1:0] ch_pin_oe,
   // Interrupt.
   output logic irq
);
   import tcct_pkg::*;
   // ==============================
   // Declarations.
   logic ext_s1_r; // External clock, first sync stage.
   logic ext_s2_r; // External clock, second sync stage.
   logic ext_s3_r; // External clock, edge history.
   logic [1:0] pin_s1_r; // Channel pins, first sync stage.
   logic [1:0] pin_s2_r; // Channel pins, second sync stage.
   logic [6:0] div_r; // Prescaler divider.
   logic [6:0] div_nxt;
   logic [15:0] cnt_r; // Timer counter.
   logic [15:0] cnt_nxt;
   logic [15:0] mod_r; // Modulo value.
   logic [15:0] mod_nxt;
   logic stop_r; // Counter stopped.
   logic stop_nxt;
   logic [2:0] sel_r; // Clock source select.
   logic [2:0] sel_nxt;
   tcct_chcfg_type cfg_r [`TCCT_NCH]; // Channel configuration.
   tcct_chcfg_type cfg_nxt [`TCCT_NCH];
   logic [15:0] val_r [`TCCT_NCH]; // Channel value registers.
   logic [15:0] val_nxt [`TCCT_NCH];
   logic act_r; // Buffered mode: channel 1 value in force.
   logic act_nxt;
   logic pend_r; // Buffered mode: last value written.
   logic pend_nxt;
   logic [`TCCT_IRQ_W-1:0] ist_r; // Sticky event status.
   logic [`TCCT_IRQ_W-1:0] ist_nxt;
   logic [`TCCT_IRQ_W-1:0] imsk_r; // Interrupt mask.
   logic [`TCCT_IRQ_W-1:0] imsk_nxt;
   logic irq_r; // Registered interrupt.
   logic irq_nxt;
   tcct_bus_state_type bus_r; // Bus answer state.
   tcct_bus_state_type bus_nxt;
   logic wait_r; // Registered waitrequest.
   logic wait_nxt;
   logic [31:0] rdata_r; // Registered read data.
   logic [31:0] rdata_nxt;
   logic [6:0] pmask; // Divider mask for the selected rate.
   logic ext_rise; // Synchronised external clock edge.
   logic src_tick; // Selected clock source pulse.
   logic tick; // Counter advances.
   logic ovf; // Counter wraps.
   logic wr_go; // Write takes effect.
   logic clr_go; // Software counter reset.
   logic [`TCCT_NCH-1:0] cap_ev; // Capture events.
   logic [`TCCT_NCH-1:0] cmp_ev; // Compare events.
   // Per-channel register addresses.
   localparam logic [5:0] CTL_A [`TCCT_NCH] = '{`TCCT_A_C0CTL, `TCCT_A_C1CTL};
   localparam logic [5:0] VAL_A [`TCCT_NCH] = '{`TCCT_A_C0VAL, `TCCT_A_C1VAL};
   // A write lands at the edge where waitrequest is seen low.
   assign wr_go = (bus_r == TCCT_BUS_ACK) && avs_write;
   assign clr_go = wr_go && (avs_address == `TCCT_A_CTRL) && avs_writedata[`TCCT_CTRL_CLR]; // RL11
   // ==============================
   // Clock source and counter.
   always_comb begin
      ext_rise = ext_s2_r && !ext_s3_r;
      div_nxt = div_r + 7'h1;
      // Rates are the bus clock divided by 1, 2, 4 up to 64.
      pmask = 7'((8'h01 << sel_r) - 8'h01); // RL8
      // The top select code picks the external pin.
      src_tick = (sel_r == `TCCT_SEL_EXT) ? ext_rise : ((div_r & pmask) == pmask); // RL12 RL9
      tick = src_tick && !stop_r && !clr_go; // RL11
      ovf = tick && (cnt_r == mod_r); // RL2
      cnt_nxt = cnt_r;
      if (clr_go) begin
         // Counter reset also restarts the prescaler.
         div_nxt = 7'h0;
         cnt_nxt = 16'h0; // RL11
      end else if (ovf) begin
         cnt_nxt = 16'h0; // RL15
      end else if (tick) begin
         cnt_nxt = cnt_r + 16'h1; // RL1
      end
   end
   // Synchronisers, divider and counter.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
         ext_s3_r <= 1'b0;
         pin_s1_r <= 2'h0;
         pin_s2_r <= 2'h0;
         div_r <= 7'h0;
         cnt_r <= 16'h0;
      end else if (ce) begin
         ext_s1_r <= ext_clk_pin;
         ext_s2_r <= ext_s1_r;
         ext_s3_r <= ext_s2_r;
         pin_s1_r <= ch_pin_in;
         pin_s2_r <= pin_s1_r;
         div_r <= div_nxt;
         cnt_r <= cnt_nxt;
      end
   end
   // ==============================
   // Software registers and events.
   always_comb begin
      stop_nxt = stop_r;
      sel_nxt = sel_r;
      mod_nxt = mod_r;
      imsk_nxt = imsk_r;
      act_nxt = act_r;
      pend_nxt = pend_r;
      for (int i = 0; i < `TCCT_NCH; i++) begin
         cfg_nxt[i] = cfg_r[i];
         val_nxt[i] = val_r[i];
         if (wr_go && avs_address == CTL_A[i]) begin
            // Only channel 0 holds the buffered link bit.
            cfg_nxt[i].link = (i == 0) ? avs_writedata[`TCCT_CH_LINK] : 1'b0;
            cfg_nxt[i].cmp = avs_writedata[`TCCT_CH_CMP]; // RL4
            cfg_nxt[i].els = tcct_edge_type'(avs_writedata[`TCCT_CH_ELS_HI:`TCCT_CH_ELS_LO]);
            cfg_nxt[i].tov = avs_writedata[`TCCT_CH_TOV];
         end
         // A capture loads the live count on every edge and beats a write.
         if (cap_ev[i]) begin
            val_nxt[i] = cnt_r; // RL14 RL13
         end else if (wr_go && avs_address == VAL_A[i]) begin
            val_nxt[i] = avs_writedata[15:0];
         end
      end
      if (wr_go) begin
         case (avs_address)
            `TCCT_A_CTRL: begin
               stop_nxt = avs_writedata[`TCCT_CTRL_STOP]; // RL11
               sel_nxt = avs_writedata[`TCCT_SEL_HI:0]; // RL12
            end
            `TCCT_A_MOD: mod_nxt = avs_writedata[15:0]; // RL2
            `TCCT_A_IMSK: imsk_nxt = avs_writedata[`TCCT_IRQ_W-1:0];
            default: ;
         endcase
      end
      // Buffered mode: the last written value takes over at overflow.
      if (!cfg_r[0].link) begin
         act_nxt = 1'b0;
         pend_nxt = 1'b0;
      end else begin
         if (wr_go && avs_address == `TCCT_A_C0VAL) begin
            pend_nxt = 1'b0;
         end else if (wr_go && avs_address == `TCCT_A_C1VAL) begin
            pend_nxt = 1'b1;
         end
         if (ovf) begin
            act_nxt = pend_r; // RL7
         end
      end
      // Writing one clears a status bit; a new event wins.
      ist_nxt = ist_r;
      if (wr_go && avs_address == `TCCT_A_IST) begin
         ist_nxt = ist_r & ~avs_writedata[`TCCT_IRQ_W-1:0];
      end
      ist_nxt = ist_nxt | {cap_ev | cmp_ev, ovf}; // RL15
      irq_nxt = |(ist_nxt & imsk_nxt);
   end
   // Software register file.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         stop_r <= `TCCT_STOP_RST;
         sel_r <= 3'h0;
         mod_r <= `TCCT_MOD_RST;
         for (int i = 0; i < `TCCT_NCH; i++) begin
            cfg_r[i] <= '0;
            val_r[i] <= 16'h0;
         end
         act_r <= 1'b0;
         pend_r <= 1'b0;
         ist_r <= '0;
         imsk_r <= '0;
         irq_r <= 1'b0;
      end else if (ce) begin
         stop_r <= stop_nxt;
         sel_r <= sel_nxt;
         mod_r <= mod_nxt;
         cfg_r <= cfg_nxt;
         val_r <= val_nxt;
         act_r <= act_nxt;
         pend_r <= pend_nxt;
         ist_r <= ist_nxt;
         imsk_r <= imsk_nxt;
         irq_r <= irq_nxt;
      end
   end
   assign irq = irq_r;
   // ==============================
   // Avalon-MM answer: one wait state for every access.
   always_comb begin
      bus_nxt = bus_r;
      wait_nxt = wait_r;
      rdata_nxt = rdata_r;
      case (bus_r)
         TCCT_BUS_IDLE: begin
            if (avs_read || avs_write) begin
               bus_nxt = TCCT_BUS_ACK;
               wait_nxt = 1'b0;
               // Reads only sample state; counting runs on.
               rdata_nxt = 32'h0; // RL3
               if (avs_read) begin
                  case (avs_address)
                     `TCCT_A_CTRL: begin
                        rdata_nxt[`TCCT_CTRL_STOP] = stop_r;
                        rdata_nxt[`TCCT_SEL_HI:0] = sel_r;
                     end
                     `TCCT_A_COUNT: rdata_nxt[15:0] = cnt_r;
                     `TCCT_A_MOD: rdata_nxt[15:0] = mod_r;
                     `TCCT_A_C0CTL: rdata_nxt[5:1] = cfg_r[0];
                     `TCCT_A_C0VAL: rdata_nxt[15:0] = val_r[0];
                     `TCCT_A_C1CTL: rdata_nxt[5:1] = cfg_r[1];
                     `TCCT_A_C1VAL: rdata_nxt[15:0] = val_r[1];
                     `TCCT_A_IST: rdata_nxt[`TCCT_IRQ_W-1:0] = ist_r;
                     `TCCT_A_IMSK: rdata_nxt[`TCCT_IRQ_W-1:0] = imsk_r;
                     default: rdata_nxt = 32'h0;
                  endcase
               end
            end
         end
         TCCT_BUS_ACK: begin
            bus_nxt = TCCT_BUS_IDLE;
            wait_nxt = 1'b1;
         end
         default: begin
            bus_nxt = TCCT_BUS_IDLE;
            wait_nxt = 1'b1;
         end
      endcase
   end
   // Bus answer registers.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bus_r <= TCCT_BUS_IDLE;
         wait_r <= 1'b1;
         rdata_r <= 32'h0;
      end else if (ce) begin
         bus_r <= bus_nxt;
         wait_r <= wait_nxt;
         rdata_r <= rdata_nxt;
      end
   end
   assign avs_waitrequest = wait_r;
   assign avs_readdata = rdata_r;
   // ==============================
   // Channels, each set up on its own.
   tcct_chan_if chif [`TCCT_NCH] ();
   for (genvar i = 0; i < `TCCT_NCH; i++) begin : g_ch
      assign chif[i].count = cnt_r;
      assign chif[i].tick = tick;
      assign chif[i].ovf = ovf;
      assign chif[i].cfg = cfg_r[i]; // RL4
      // Linked channel 0 compares against the value in force.
      assign chif[i].cmp_val = (i == 0 && cfg_r[0].link && act_r) ? val_r[1] : val_r[i]; // RL7
      // Channel 1 gives up its pin while linked.
      assign chif[i].drive_en = (i == 0) || !cfg_r[0].link;
      assign chif[i].pin_sync = pin_s2_r[i];
      assign cap_ev[i] = chif[i].cap_ev;
      assign cmp_ev[i] = chif[i].cmp_ev;
      assign ch_pin_out[i] = chif[i].pin_out;
      assign ch_pin_oe[i] = chif[i].pin_oe;
      tcct_channel u_ch (
         .ref_clk(ref_clk),
         .rst(rst),
         .ce(ce),
         .ch(chif[i].chan)
      );
   end
   // ==============================
   // Checks.
   cnt_step_a: assert property (@(posedge ref_clk) disable iff (rst) // RL1
      ce && tick && cnt_r != mod_r |=> cnt_r == $past(cnt_r) + 16'h1)
      else $error("counter did not step");
   cnt_wrap_a: assert property (@(posedge ref_clk) disable iff (rst) // RL15
      ce && tick && cnt_r == mod_r |=> cnt_r == 16'h0 && ist_r[`TCCT_IRQ_OVF])
      else $error("counter did not wrap at modulo");
   cnt_quiet_a: assert property (@(posedge ref_clk) disable iff (rst) // RL3
      ce && !tick && !clr_go |=> $stable(cnt_r))
      else $error("counter moved without a tick");
   mod_load_a: assert property (@(posedge ref_clk) disable iff (rst) // RL2
      ce && wr_go && avs_address == `TCCT_A_MOD |=> mod_r == $past(avs_writedata[15:0]))
      else $error("modulo not loaded");
   clr_zero_a: assert property (@(posedge ref_clk) disable iff (rst) // RL11
      ce && clr_go |=> cnt_r == 16'h0 && div_r == 7'h0)
      else $error("counter reset failed");
   stop_hold_a: assert property (@(posedge ref_clk) disable iff (rst) // RL11
      stop_r |-> !tick && !ovf)
      else $error("stopped counter ticked");
   sequence half_tick_s;
      ce && sel_r == 3'h1 && tick;
   endsequence
   presc_half_a: assert property (@(posedge ref_clk) disable iff (rst) // RL8
      half_tick_s ##1 sel_r == 3'h1 |-> !tick)
      else $error("divide by two ticked twice in a row");
   sequence ext_run_s;
      ce && sel_r == `TCCT_SEL_EXT && !stop_r && !clr_go;
   endsequence
   ext_tick_a: assert property (@(posedge ref_clk) disable iff (rst) // RL9 RL12
      (ext_run_s and ($rose(ext_clk_pin) && !ext_s1_r)) ##1 ext_run_s [*2] |-> tick)
      else $error("external edge did not tick");
   cap_load_a: assert property (@(posedge ref_clk) disable iff (rst) // RL14
      ce && cap_ev[0] |=> val_r[0] == $past(cnt_r) && ist_r[1])
      else $error("capture not loaded");
   sequence pin0_rise_s;
      ce && !cfg_r[0].cmp && cfg_r[0].els == TCCT_ELS_RISE_TOG && sel_r == 3'h0 && !stop_r
      && !wr_go && mod_r > 16'h3 && cnt_r < mod_r - 16'h3 && !pin_s1_r[0] && $rose(ch_pin_in[0]);
   endsequence
   sequence run_quiet_s;
      ce && !wr_go && sel_r == 3'h0 && !stop_r;
   endsequence
   cap_lat_a: assert property (@(posedge ref_clk) disable iff (rst) // RL13
      pin0_rise_s ##1 run_quiet_s [*2] |=> val_r[0] == $past(cnt_r, 3) + 16'h2)
      else $error("capture latency not two");
   buf_swap_a: assert property (@(posedge ref_clk) disable iff (rst) // RL7
      ce && cfg_r[0].link && ovf |=> act_r == $past(pend_r))
      else $error("buffered value not swapped at overflow");
endmodule

/* dv/tcct_pin_model.sv */
// Far-side model of the timer pins: channel pin levels and external clock.
`timescale 1ns/100ps
module tcct_pin_model (
   // Pin drive from the timer.
   input wire logic [1:0] pin_out,
   input wire logic [1:0] pin_oe,
   // Levels seen by the timer.
   output logic [1:0] pin_in,
   output logic ext_clk
);
   logic [1:0] lvl = 2'h0; // Level the far side puts on each pin.
   // The wire follows the timer while it drives, else the far side.
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & lvl);
   initial ext_clk = 1'b0;
   // Sends n pulses at 4 MHz, then the clock stands still low.
   task automatic ext_pulses(input int n);
      // Step off the bus clock edge so the pin never races a sample.
      #1;
      repeat (n) begin
         #125 ext_clk = 1'b1;
         #125 ext_clk = 1'b0;
      end
   endtask
   // Moves one far-side pin level.
   task automatic set_lvl(input int i, input logic v);
      lvl[i] <= v;
   endtask
endmodule

/* dv/tcct_top_test.sv */
// Self-checking bench of the two-channel capture/compare timer.
`timescale 1ns/100ps
`include "tcct_defs.svh"
module tcct_top_test;
   import tcct_pkg::*;
   logic ref_clk, rst, ce, avs_read, avs_write, avs_waitrequest, ext_clk_pin, irq;
   logic [5:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd, v0;
   logic [1:0] ch_pin_in, ch_pin_out, ch_pin_oe;
   int miscompares = 0;
   int checks_done = 0;
   int cyc = 0;
   // ==============================
   // Design and pin partner.
   tcct_top DUT (.ref_clk(ref_clk), .rst(rst), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .ext_clk_pin(ext_clk_pin), .ch_pin_in(ch_pin_in),
      .ch_pin_out(ch_pin_out), .ch_pin_oe(ch_pin_oe), .irq(irq));
   tcct_pin_model M (.pin_out(ch_pin_out), .pin_oe(ch_pin_oe), .pin_in(ch_pin_in), .ext_clk(ext_clk_pin));
   // Clock of 5 ns period.
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   // A hang is cut short and counted as a mismatch.
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         give_verdict();
      end
   end
   // ==============================
   // Prints counts and the verdict, then ends the run.
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Compares a value with its expectation.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Checks that a value lies within a range.
   task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
      checks_done++;
      if (!(got >= lo && got <= hi)) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h lo=%h", $time, got, lo);
      end
   endtask
   // One Avalon access; the request stands until waitrequest is sampled low.
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !w;
      avs_write <= w;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 100);
      if (n >= 100) miscompares++;
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   // Counts high cycles of channel 0 pin over one 100-cycle period.
   task automatic duty(input logic [31:0] lo, input logic [31:0] hi);
      int n;
      n = 0;
      repeat (200) @(posedge ref_clk);
      repeat (100) begin
         @(posedge ref_clk);
         if (ch_pin_out[0] === 1'b1) n++;
      end
      chk_rng(32'(n), lo, hi);
   endtask
   // ==============================
   // Reset values and an unmapped address.
   task automatic t_reset();
      rdc(`TCCT_A_CTRL, 32'h20);
      rdc(`TCCT_A_MOD, 32'hffff);
      rdc(`TCCT_A_IST, 32'h0);
      rdc(6'h24, 32'h0);
   endtask
   // Modulo wrap, overflow flag, interrupt, free run, stop and counter reset.
   task automatic t_mod();
      wr(`TCCT_A_MOD, 32'h9);
      wr(`TCCT_A_IMSK, 32'h1);
      wr(`TCCT_A_CTRL, 32'h0);
      for (int i = 0; i < 4; i++) begin
         bus(1'b0, `TCCT_A_COUNT, 32'h0);
         chk_rng(rd, 32'h0, 32'h9);
      end
      rdc(`TCCT_A_IST, 32'h1);
      chk(32'(irq), 32'h1);
      wr(`TCCT_A_IMSK, 32'h0);
      repeat (3) @(posedge ref_clk);
      chk(32'(irq), 32'h0);
      wr(`TCCT_A_MOD, 32'hffff);
      repeat (50) @(posedge ref_clk);
      bus(1'b0, `TCCT_A_COUNT, 32'h0);
      chk_rng(rd, 32'ha, 32'hc8);
      // A low clock enable freezes the running counter.
      v0 = rd;
      ce <= 1'b0;
      repeat (50) @(posedge ref_clk);
      ce <= 1'b1;
      bus(1'b0, `TCCT_A_COUNT, 32'h0);
      chk_rng(rd - v0, 32'h1, 32'h8);
      wr(`TCCT_A_CTRL, 32'h20);
      bus(1'b0, `TCCT_A_COUNT, 32'h0);
      rdc(`TCCT_A_COUNT, rd);
      wr(`TCCT_A_CTRL, 32'h30);
      rdc(`TCCT_A_COUNT, 32'h0);
      wr(`TCCT_A_IST, 32'h1);
      rdc(`TCCT_A_IST, 32'h0);
   endtask
   // Each bus clock division counts a 256-cycle window.
   task automatic t_pre();
      for (int s = 0; s < 7; s++) begin
         wr(`TCCT_A_CTRL, 32'h30);
         wr(`TCCT_A_CTRL, 32'(s));
         repeat (256) @(posedge ref_clk);
         wr(`TCCT_A_CTRL, 32'h20);
         bus(1'b0, `TCCT_A_COUNT, 32'h0);
         chk_rng(rd, 32'(256 >> s), 32'((264 >> s) + 1));
      end
   endtask
   // External clock pin drives the counter.
   task automatic t_ext();
      wr(`TCCT_A_CTRL, 32'h37);
      wr(`TCCT_A_CTRL, 32'h07);
      M.ext_pulses(5);
      repeat (4) @(posedge ref_clk);
      rdc(`TCCT_A_COUNT, 32'h5);
   endtask
   // Edge selection per mode, then capture spacing on two channels.
   task automatic t_cap();
      for (int m = 1; m < 4; m++) begin
         wr(`TCCT_A_C1CTL, 32'(m << 2));
         for (int e = 0; e < 2; e++) begin
            wr(`TCCT_A_IST, 32'h7);
            @(posedge ref_clk);
            M.set_lvl(1, e == 0);
            repeat (6) @(posedge ref_clk);
            bus(1'b0, `TCCT_A_IST, 32'h0);
            chk(32'(rd[2]), 32'(m[e]));
         end
      end
      wr(`TCCT_A_CTRL, 32'h30);
      wr(`TCCT_A_C0CTL, 32'h04);
      wr(`TCCT_A_C1CTL, 32'h0c);
      wr(`TCCT_A_CTRL, 32'h0);
      @(posedge ref_clk);
      M.set_lvl(0, 1'b1);
      M.set_lvl(1, 1'b1);
      repeat (40) @(posedge ref_clk);
      M.set_lvl(1, 1'b0);
      repeat (8) @(posedge ref_clk);
      bus(1'b0, `TCCT_A_C0VAL, 32'h0);
      v0 = rd;
      bus(1'b0, `TCCT_A_C1VAL, 32'h0);
      chk(rd - v0, 32'd40);
   endtask
   // Compare actions and overflow toggle on channel 0.
   task automatic cmp_case(input logic [31:0] ctl, input int kind);
      logic p;
      wr(`TCCT_A_C0CTL, ctl);
      wr(`TCCT_A_IST, 32'h7);
      repeat (120) @(posedge ref_clk);
      p = ch_pin_out[0];
      if (kind < 2) chk(32'(p), 32'(kind));
      else begin
         repeat (100) @(posedge ref_clk);
         chk(32'(ch_pin_out[0]), 32'(!p));
      end
      chk(32'(ch_pin_oe), 32'h1);
      bus(1'b0, `TCCT_A_IST, 32'h0);
      chk(32'(rd[1]), 32'h1);
   endtask
   task automatic t_cmp();
      wr(`TCCT_A_C1CTL, 32'h0);
      wr(`TCCT_A_MOD, 32'd99);
      wr(`TCCT_A_C0VAL, 32'd50);
      cmp_case(32'h1c, 1);
      cmp_case(32'h18, 0);
      cmp_case(32'h14, 2);
      cmp_case(32'h12, 2);
   endtask
   // Unbuffered then buffered PWM; the last written value rules.
   task automatic t_pwm();
      wr(`TCCT_A_C0VAL, 32'd30);
      wr(`TCCT_A_C0CTL, 32'h1a);
      duty(32'd29, 32'd32);
      wr(`TCCT_A_C1CTL, 32'h1c);
      wr(`TCCT_A_C0CTL, 32'h3a);
      wr(`TCCT_A_C1VAL, 32'd70);
      duty(32'd69, 32'd72);
      chk(32'(ch_pin_oe[1]), 32'h0);
      wr(`TCCT_A_C0VAL, 32'd10);
      duty(32'd9, 32'd12);
   endtask
   // ==============================
   // Main sequence.
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 6'h0;
      avs_writedata = 32'h0;
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset();
      t_mod();
      t_pre();
      t_ext();
      t_cap();
      t_cmp();
      t_pwm();
      give_verdict();
   end
endmodule
